//--- stepper_defs.svh
// Constants for the stepper pulse mode sequencer: command codes, bit positions, resets
`ifndef STEPPER_DEFS_SVH
`define STEPPER_DEFS_SVH
// Command group in bits 7:6
`define GRP_START 2'h0
`define GRP_CTRL 2'h1
`define GRP_REGSEL 2'h2
`define GRP_OUTPUT 2'h3
// Start mode command codes and bits
`define CMD_STOP_NOW 8'h08
`define CMD_STOP_DECEL 8'h1D
`define CMD_START_RUN 8'h11
`define CMD_START_ACCEL 8'h15
`define CMD_START_LOW_INT 8'h30
`define START_GO_BIT 4
`define START_RUN_BIT 0
`define START_ACCEL_BIT 2
`define START_INT_BIT 5
`define START_STOP_BIT 3
// Control mode command bits (44h positioning, 45h origin with feed limit)
`define CTRL_ORIGIN_BIT 0
`define CTRL_SLOW_BIT 1
`define CTRL_FEED_BIT 2
`define CTRL_DIR_BIT 3
// Output mode command bit (E0h output, E2h masked)
`define OUT_MASK_BIT 1
// Register selection codes (low three bits of 80h..87h)
`define SEL_FEED 3'h0
`define SEL_START_SPD 3'h1
`define SEL_RUN_SPD 3'h2
`define SEL_ACCEL 3'h3
`define SEL_MULT 3'h4
`define SEL_ENV 3'h7
// Environment register bits (low byte 02h extended, 0Ah with auto ramp-down)
`define ENV_EXT_BIT 1
`define ENV_AUTO_RAMP_BIT 3
`define ENV_PSTP_BIT 8
// Widths and reset values
`define SPEED_W 13
`define MULT_W 10
`define ACCEL_W 16
`define DATA_W 24
`define SPEED_SHIFT 13
`define RST_START_SPD 13'h0001
`define RST_RUN_SPD 13'h0001
`define RST_ACCEL 16'h0001
`define RST_MULT 10'h258
`define RST_ENV 24'h000000
`endif

//--- stepper_pkg.sv
// Types shared by the stepper pulse mode sequencer
package stepper_pkg;
  typedef enum logic [2:0] {
    ST_IDLE = 3'b001,
    ST_RUN = 3'b010,
    ST_DSTOP = 3'b100
  } run_state_e;

  typedef struct packed {
    logic direction_select_bit;
    logic max_feed_enable_bit;
    logic slowdown_enable_bit;
    logic origin_mode;
  } ctrl_mode_s;

  typedef struct packed {
    logic accel;
    logic use_run_speed;
    logic int_on_stop;
  } start_mode_s;
endpackage

//--- pulse_rate_gen.sv
// Pulse rate generator: rate = speed * clock / (multiplier * 8192)
`include "stepper_defs.svh"
module pulse_rate_gen #(
  parameter int SPEED_W = `SPEED_W,
  parameter int MULT_W = `MULT_W
) (
  input wire logic core_clk, // System clock
  input wire logic reset_n, // Synchronous reset, active low
  input wire logic run, // Generate pulses while high
  input wire logic [SPEED_W-1:0] speed, // Speed setting
  input wire logic [MULT_W-1:0] mult, // Speed multiplier setting
  output logic tick_q // One cycle per generated pulse
);
  localparam int ACC_W = MULT_W + `SPEED_SHIFT + 1;
  logic [ACC_W-1:0] acc_q;
  logic [ACC_W-1:0] sum;
  logic [ACC_W-1:0] limit;

  // Rate accumulator; exact average rate, no divider needed
  assign limit = {1'b0, mult, {`SPEED_SHIFT{1'b0}}};
  assign sum = acc_q + {{(ACC_W-SPEED_W){1'b0}}, speed};

  always_ff @(posedge core_clk) begin
    if (!reset_n || !run) begin
      acc_q <= '0;
      tick_q <= 1'b0;
    end else if (sum >= limit) begin
      acc_q <= sum - limit;
      tick_q <= 1'b1;
    end else begin
      acc_q <= sum;
      tick_q <= 1'b0;
    end
  end
endmodule // pulse_rate_gen

//--- stepper_pulse_mode_sequencer.sv
// Operating-mode sequencer: origin return, positioning and timer mode
`include "stepper_defs.svh"
// Operation
// - Origin return with slowdown: decelerate on slowdown low, stop on origin low.
// - Code 45h: origin return plus, stop on origin or feed count done.
// - Positioning: feed counter drops per pulse; stop at zero.
// - Start with feed zero: no motion, stop interrupt still given.
// - Direction bit: 0 plus, 1 minus.
// - Slowdown enable: 0 ignore input, 1 decelerate to start speed.
// - Pulse output control: 0 pulses out, 1 suppressed.
// - Position count stop: 0 count every pulse, 1 hold.
// - 44h positioning plus; E0h extended monitor with pulses.
// - Environment low byte 02h extended, 0Ah extended with auto ramp-down.
// - Codes 80h-84h, 87h select registers for following data bytes.
// - 11h run speed, 15h accelerate, 30h start speed with interrupt.
// - E2h timer mode: full count run, no pulses to motor.
// - Timer time is pulse period times preset count; stop interrupt.
// - Timer mode stops on count end, stop input or stop command, never on limit or origin.
// - Max-feed bit makes origin return count down feed counter.
// - Start with origin already low: no motion, interrupt still given.
module stepper_pulse_mode_sequencer
  import stepper_pkg::*;
(
  input wire logic core_clk, // 10 MHz system clock
  input wire logic reset_n, // Synchronous reset, active low
  input wire logic cmd_wr, // Command buffer write strobe
  input wire logic [7:0] cmd_data, // Command buffer byte
  input wire logic reg_wr, // Register write buffer strobe
  input wire logic [7:0] reg_data, // Register write buffer byte
  input wire logic origin_input_n, // Origin sensor pin, low active
  input wire logic slowdown_input_n, // Slowdown sensor pin, low active
  input wire logic stop_input_n, // Stop pin, low active
  input wire logic end_limit_input_n, // End limit pin, low active
  output logic pulse_out_q, // Motor pulse, one cycle each
  output logic dir_out_q, // Direction, high for minus
  output logic int_out_q, // Stop interrupt pulse
  output logic busy_q, // Motor running
  output logic [23:0] feed_amount_counter, // Feed amount counter
  output logic [23:0] current_position_counter, // Current position counter
  output logic ext_mode_q, // Extended-function mode
  output logic auto_ramp_q // Automatic ramp-down point mode
);
  ////////////////////////////////////////////////////////////////////////
  // Pin synchronisers: bit 0 origin, 1 slowdown, 2 stop, 3 end limit
  logic [3:0] pin_raw;
  logic [3:0] pin_meta_q;
  logic [3:0] pin_sync_q;
  assign pin_raw = {end_limit_input_n, stop_input_n, slowdown_input_n, origin_input_n};
  generate
    for (genvar i = 0; i < 4; i++) begin : g_sync
      always_ff @(posedge core_clk) begin
        if (!reset_n) begin
          pin_meta_q[i] <= 1'b1;
          pin_sync_q[i] <= 1'b1;
        end else begin
          pin_meta_q[i] <= pin_raw[i];
          pin_sync_q[i] <= pin_meta_q[i];
        end
      end
    end
  endgenerate
  logic origin_low, slow_low, stop_low, limit_low;
  assign origin_low = !pin_sync_q[0];
  assign slow_low = !pin_sync_q[1];
  assign stop_low = !pin_sync_q[2];
  assign limit_low = !pin_sync_q[3];

  ////////////////////////////////////////////////////////////////////////
  // Command decode
  logic grp_start, grp_ctrl, grp_sel, grp_out;
  logic is_start, is_istop, is_dstop;
  assign grp_start = cmd_wr && (cmd_data[7:6] == `GRP_START);
  assign grp_ctrl = cmd_wr && (cmd_data[7:6] == `GRP_CTRL);
  assign grp_sel = cmd_wr && (cmd_data[7:6] == `GRP_REGSEL);
  assign grp_out = cmd_wr && (cmd_data[7:6] == `GRP_OUTPUT);
  assign is_start = grp_start && cmd_data[`START_GO_BIT] && !cmd_data[`START_STOP_BIT];
  assign is_istop = cmd_wr && (cmd_data == `CMD_STOP_NOW);
  assign is_dstop = cmd_wr && (cmd_data == `CMD_STOP_DECEL);

  ctrl_mode_s ctrl_q;
  logic pulse_output_control_bit;
  // mode bits latched from control and output commands
  always_ff @(posedge core_clk) begin
    if (!reset_n) begin
      ctrl_q <= '0;
      pulse_output_control_bit <= 1'b0;
    end else begin
      if (grp_ctrl) begin
        ctrl_q.direction_select_bit <= cmd_data[`CTRL_DIR_BIT];
        ctrl_q.max_feed_enable_bit <= cmd_data[`CTRL_FEED_BIT];
        ctrl_q.slowdown_enable_bit <= cmd_data[`CTRL_SLOW_BIT];
        ctrl_q.origin_mode <= cmd_data[`CTRL_ORIGIN_BIT];
      end
      if (grp_out) begin
        pulse_output_control_bit <= cmd_data[`OUT_MASK_BIT];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Register selection and data bytes
  logic [2:0] sel_q;
  logic [23:0] shadow_q;
  logic [23:0] shadow_d;
  logic [12:0] start_speed_setting;
  logic [12:0] run_speed_setting;
  logic [15:0] accel_rate_setting;
  logic [9:0] speed_multiplier_setting;
  logic [23:0] env_q;
  assign shadow_d = {shadow_q[15:0], reg_data};

  // bytes shift in high first; each byte commits, so upper may be skipped
  always_ff @(posedge core_clk) begin
    if (!reset_n) begin
      sel_q <= `SEL_FEED;
      shadow_q <= '0;
      start_speed_setting <= `RST_START_SPD;
      run_speed_setting <= `RST_RUN_SPD;
      accel_rate_setting <= `RST_ACCEL;
      speed_multiplier_setting <= `RST_MULT;
      env_q <= `RST_ENV;
    end else if (grp_sel) begin
      sel_q <= cmd_data[2:0];
      shadow_q <= '0;
    end else if (reg_wr) begin
      shadow_q <= shadow_d;
      case (sel_q)
        `SEL_START_SPD: start_speed_setting <= shadow_d[12:0];
        `SEL_RUN_SPD: run_speed_setting <= shadow_d[12:0];
        `SEL_ACCEL: accel_rate_setting <= shadow_d[15:0];
        `SEL_MULT: speed_multiplier_setting <= shadow_d[9:0];
        `SEL_ENV: env_q <= shadow_d;
        default: ;
      endcase
    end
  end
  // mode flags straight from the environment register
  assign ext_mode_q = env_q[`ENV_EXT_BIT];
  assign auto_ramp_q = env_q[`ENV_AUTO_RAMP_BIT];

  ////////////////////////////////////////////////////////////////////////
  // Run control
  run_state_e state_q;
  start_mode_s smode_q;
  logic tick;
  logic counting, timer_mode, last_pulse, blocked, stop_now;
  logic [12:0] cur_speed_q;
  logic at_start_speed;
  logic feed_wr;
  assign feed_wr = reg_wr && !grp_sel && (sel_q == `SEL_FEED);
  // feed counter counts in positioning and feed-limited origin return
  assign counting = ctrl_q.max_feed_enable_bit;
  // timer mode is positioning with pulses masked
  assign timer_mode = counting && !ctrl_q.origin_mode && pulse_output_control_bit;
  assign last_pulse = tick && counting && (feed_amount_counter == 24'h000001);
  // refuse a start that would end at once
  assign blocked = (counting && (feed_amount_counter == '0)) ||
                   (ctrl_q.origin_mode && origin_low);
  // stop sources; timer mode ignores limit and origin
  assign stop_now = stop_low || is_istop || last_pulse ||
                    (!timer_mode && (limit_low || (ctrl_q.origin_mode && origin_low)));
  assign at_start_speed = (cur_speed_q <= start_speed_setting);

  // State machine; interrupt pulses on every stop when enabled
  always_ff @(posedge core_clk) begin
    if (!reset_n) begin
      state_q <= ST_IDLE;
      smode_q <= '0;
      int_out_q <= 1'b0;
      busy_q <= 1'b0;
    end else begin
      int_out_q <= 1'b0;
      case (state_q)
        ST_IDLE: begin
          // stop commands fall through here untouched
          if (is_start) begin
            smode_q.accel <= cmd_data[`START_ACCEL_BIT];
            smode_q.use_run_speed <= cmd_data[`START_RUN_BIT];
            smode_q.int_on_stop <= cmd_data[`START_INT_BIT];
            // no motion but interrupt still raised
            if (blocked) begin
              int_out_q <= cmd_data[`START_INT_BIT];
            end else begin
              state_q <= ST_RUN;
              busy_q <= 1'b1;
            end
          end
        end
        ST_RUN, ST_DSTOP: begin
          if (stop_now || (state_q == ST_DSTOP && at_start_speed)) begin
            state_q <= ST_IDLE;
            busy_q <= 1'b0;
            int_out_q <= smode_q.int_on_stop;
          end else if (is_dstop) begin
            state_q <= ST_DSTOP;
          end
        end
        default: begin
          state_q <= ST_IDLE;
          busy_q <= 1'b0;
        end
      endcase
    end
  end

  // Speed profile; ramps one step per accel_rate cycles, else jumps
  logic [15:0] ramp_cnt_q;
  logic slow_req;
  logic [12:0] target;
  // slowdown input only honoured when enabled
  assign slow_req = (ctrl_q.slowdown_enable_bit && slow_low) || (state_q == ST_DSTOP);
  assign target = (slow_req || !smode_q.use_run_speed) ? start_speed_setting : run_speed_setting;
  always_ff @(posedge core_clk) begin
    if (!reset_n || state_q == ST_IDLE) begin
      cur_speed_q <= start_speed_setting;
      ramp_cnt_q <= '0;
    end else if (!smode_q.accel) begin
      cur_speed_q <= target;
    end else if (ramp_cnt_q + 16'h0001 >= accel_rate_setting) begin
      ramp_cnt_q <= '0;
      if (cur_speed_q < target) begin
        cur_speed_q <= cur_speed_q + 13'h0001;
      end else if (cur_speed_q > target) begin
        cur_speed_q <= cur_speed_q - 13'h0001;
      end
    end else begin
      ramp_cnt_q <= ramp_cnt_q + 16'h0001;
    end
  end

  pulse_rate_gen #(
    .SPEED_W(`SPEED_W),
    .MULT_W(`MULT_W)
  ) u_rate (
    .core_clk(core_clk),
    .reset_n(reset_n),
    .run(state_q != ST_IDLE),
    .speed(cur_speed_q),
    .mult(speed_multiplier_setting),
    .tick_q(tick)
  );

  ////////////////////////////////////////////////////////////////////////
  // Counters and pins
  logic running;
  assign running = (state_q != ST_IDLE);
  // feed counter decrements per pulse; left at zero after a run that counts out
  always_ff @(posedge core_clk) begin
    if (!reset_n) begin
      feed_amount_counter <= '0;
    end else if (feed_wr) begin
      feed_amount_counter <= shadow_d;
    end else if (running && tick && counting && feed_amount_counter != '0) begin
      feed_amount_counter <= feed_amount_counter - 24'h000001;
    end
  end

  // position counts every pulse, even masked, unless held
  always_ff @(posedge core_clk) begin
    if (!reset_n) begin
      current_position_counter <= '0;
    end else if (running && tick && !env_q[`ENV_PSTP_BIT]) begin
      if (ctrl_q.direction_select_bit) begin
        current_position_counter <= current_position_counter - 24'h000001;
      end else begin
        current_position_counter <= current_position_counter + 24'h000001;
      end
    end
  end

  // pulses gated by the output control bit; direction out
  always_ff @(posedge core_clk) begin
    if (!reset_n) begin
      pulse_out_q <= 1'b0;
      dir_out_q <= 1'b0;
    end else begin
      pulse_out_q <= running && tick && !pulse_output_control_bit;
      dir_out_q <= ctrl_q.direction_select_bit;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Checks
  a_feed_decrement: assert property (@(posedge core_clk) disable iff (!reset_n)
    running && tick && counting && !feed_wr && feed_amount_counter != '0
    |=> feed_amount_counter == $past(feed_amount_counter) - 24'h000001)
    else $error("feed counter did not step down");
  a_feed_end_stop: assert property (@(posedge core_clk) disable iff (!reset_n)
    running && last_pulse |=> state_q == ST_IDLE && !busy_q)
    else $error("run did not end at last pulse");
  a_zero_start: assert property (@(posedge core_clk) disable iff (!reset_n)
    state_q == ST_IDLE && is_start && counting && feed_amount_counter == '0
    |=> state_q == ST_IDLE && int_out_q == $past(cmd_data[`START_INT_BIT]))
    else $error("start with zero feed misbehaved");
  a_origin_start: assert property (@(posedge core_clk) disable iff (!reset_n)
    state_q == ST_IDLE && is_start && ctrl_q.origin_mode && origin_low
    |=> !busy_q)
    else $error("started with origin low");
  a_origin_stop: assert property (@(posedge core_clk) disable iff (!reset_n)
    running && ctrl_q.origin_mode && origin_low && !timer_mode |=> state_q == ST_IDLE)
    else $error("origin did not stop motion");
  a_mask_pulse: assert property (@(posedge core_clk) disable iff (!reset_n)
    pulse_output_control_bit && $past(pulse_output_control_bit) |-> !pulse_out_q)
    else $error("pulse escaped while masked");
  a_pos_hold: assert property (@(posedge core_clk) disable iff (!reset_n)
    env_q[`ENV_PSTP_BIT] |=> $stable(current_position_counter))
    else $error("position counted while held");
  a_timer_ignore: assert property (@(posedge core_clk) disable iff (!reset_n)
    state_q == ST_RUN && timer_mode && !stop_low && !is_istop && !last_pulse
    |=> running)
    else $error("timer stopped by limit or origin");
  a_idle_stop: assert property (@(posedge core_clk) disable iff (!reset_n)
    state_q == ST_IDLE && is_istop && !reg_wr
    |=> $stable(feed_amount_counter) && !int_out_q && !busy_q)
    else $error("idle stop had an effect");
  a_dir_follow: assert property (@(posedge core_clk) disable iff (!reset_n)
    grp_ctrl |=> ##1 dir_out_q == $past(cmd_data[`CTRL_DIR_BIT], 2))
    else $error("direction not taken");
endmodule // stepper_pulse_mode_sequencer

//--- host_model.sv
// Host model: writes command bytes and register bytes into the sequencer
module host_model (
  input wire logic core_clk, // System clock
  output logic cmd_wr, // Command strobe
  output logic [7:0] cmd_data, // Command byte
  output logic reg_wr, // Data strobe
  output logic [7:0] reg_data // Data byte
);
  timeunit 1ns;
  timeprecision 1ns;

  // Idle bus at time zero
  initial begin
    cmd_wr = 1'b0;
    reg_wr = 1'b0;
    cmd_data = 8'hA5;
    reg_data = 8'h5A;
  end

  ////////////////////////////////////////////////////////////////////////////
  // One byte per strobe; released lines show the inverse so stale data never matches
  task automatic send_cmd(input logic [7:0] b);
    @(negedge core_clk);
    cmd_wr = 1'b1;
    cmd_data = b;
    @(negedge core_clk);
    cmd_wr = 1'b0;
    cmd_data = ~b;
  endtask

  task automatic write_reg(input logic [7:0] sel, input logic [23:0] v);
    send_cmd(sel);
    for (int i = 2; i >= 0; i--) begin
      @(negedge core_clk);
      reg_wr = 1'b1;
      reg_data = v[8*i +: 8];
      @(negedge core_clk);
      reg_wr = 1'b0;
      reg_data = ~v[8*i +: 8];
    end
  endtask
endmodule // host_model

//--- stepper_pulse_mode_sequencer_tb_top.sv
// Self-checking bench for the stepper pulse mode sequencer
module stepper_pulse_mode_sequencer_tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  logic core_clk, reset_n, cmd_wr, reg_wr, origin_n, slow_n, stop_n, limit_n;
  logic [7:0] cmd_data, reg_data, ctl, st;
  logic pulse_out_q, dir_out_q, int_out_q, busy_q, ext_mode_q, auto_ramp_q;
  logic [23:0] feed_amount_counter, current_position_counter, exp_pos, n, sf, sp;
  logic [7:0] starts [3] = '{8'h11, 8'h15, 8'h30};
  int mismatches, checked, npul, nint, nbusy, cyc;

  host_model host (.core_clk(core_clk), .cmd_wr(cmd_wr), .cmd_data(cmd_data),
    .reg_wr(reg_wr), .reg_data(reg_data));

  stepper_pulse_mode_sequencer uut (.core_clk(core_clk), .reset_n(reset_n), .cmd_wr(cmd_wr),
    .cmd_data(cmd_data), .reg_wr(reg_wr), .reg_data(reg_data), .origin_input_n(origin_n),
    .slowdown_input_n(slow_n), .stop_input_n(stop_n), .end_limit_input_n(limit_n),
    .pulse_out_q(pulse_out_q), .dir_out_q(dir_out_q), .int_out_q(int_out_q), .busy_q(busy_q),
    .feed_amount_counter(feed_amount_counter),
    .current_position_counter(current_position_counter), .ext_mode_q(ext_mode_q),
    .auto_ramp_q(auto_ramp_q));

  // 10 MHz clock
  initial begin
    core_clk = 1'b0;
    forever #50 core_clk = ~core_clk;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Pulse, interrupt and busy tallies; the cycle ceiling cuts a hang short
  always @(posedge core_clk) begin
    cyc++;
    if (pulse_out_q === 1'b1) npul++;
    if (int_out_q === 1'b1) nint++;
    if (busy_q === 1'b1) nbusy++;
    if (cyc == 40000) begin
      mismatches++;
      tally_and_finish();
    end
  end

  task automatic tally_and_finish();
    $display("mismatches=%0d checked=%0d", mismatches, checked);
    if (mismatches == 0 && checked > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask

  task automatic chk24(input logic [23:0] got, input logic [23:0] exp);
    checked++;
    if (got !== exp) begin
      mismatches++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic chk1(input logic got, input logic exp);
    checked++;
    if (got !== exp) begin
      mismatches++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // Plus runs add, minus runs subtract, a held counter keeps its value
  function automatic logic [23:0] next_pos(logic [23:0] p, logic [7:0] c, logic [23:0] k,
    logic hold);
    return hold ? p : (c[3] ? p - k : p + k);
  endfunction

  task automatic start_run(input logic [7:0] c, input logic [7:0] o, input logic [23:0] f,
    input logic [7:0] s);
    host.send_cmd(c);
    host.send_cmd(o);
    host.write_reg(8'h80, f);
    npul = 0;
    nint = 0;
    nbusy = 0;
    host.send_cmd(s);
  endtask

  // Waits out a run; the global ceiling bounds a run that never ends
  task automatic run(input logic [7:0] c, input logic [7:0] o, input logic [23:0] f,
    input logic [7:0] s);
    start_run(c, o, f, s);
    repeat (3) @(negedge core_clk);
    while (busy_q !== 1'b0) @(negedge core_clk);
    repeat (3) @(negedge core_clk);
  endtask

  ////////////////////////////////////////////////////////////////////////////
  // Main sequence
  initial begin
    reset_n = 1'b0;
    {origin_n, slow_n, stop_n, limit_n} = 4'hF;
    {mismatches, checked, npul, nint, nbusy, cyc} = '0;
    exp_pos = 24'h000000;
    n = 24'($urandom(32'h2A4B));
    repeat (3) @(negedge core_clk);
    reset_n = 1'b1;
    chk24(feed_amount_counter, 24'h000000);
    chk24(current_position_counter, 24'h000000);
    chk1(busy_q, 1'b0);
    host.write_reg(8'h87, 24'h00000A);
    repeat (2) @(negedge core_clk);
    chk1(ext_mode_q, 1'b1);
    chk1(auto_ramp_q, 1'b1);
    host.write_reg(8'h87, 24'h000002);
    repeat (2) @(negedge core_clk);
    chk1(auto_ramp_q, 1'b0);
    // Equal speeds, multiplier 2: one pulse every 4 cycles
    host.write_reg(8'h81, 24'h001000);
    host.write_reg(8'h82, 24'h001000);
    host.write_reg(8'h83, 24'h000001);
    host.write_reg(8'h84, 24'h000002);
    for (int i = 0; i < 6; i++) begin
      ctl = 8'h44 | (8'($urandom_range(1)) << 3);
      st = starts[i % 3];
      n = (i == 0) ? 24'h000001 : 24'($urandom_range(16, 1));
      run(ctl, 8'hE0, n, st);
      chk24(24'(npul), n);
      chk24(feed_amount_counter, 24'h000000);
      chk24(24'(nint), 24'(st == 8'h30));
      exp_pos = next_pos(exp_pos, ctl, n, 1'b0);
      chk24(current_position_counter, exp_pos);
      chk1(dir_out_q, ctl[3]);
    end
    run(8'h44, 8'hE0, 24'h000000, 8'h30);
    chk24(24'(nbusy), 24'h000000);
    chk24(24'(nint), 24'h000001);
    {origin_n, limit_n} = 2'b00;
    run(8'h44, 8'hE2, 24'd50, 8'h30);
    {origin_n, limit_n} = 2'b11;
    chk24(24'(npul), 24'h000000);
    chk24(24'(nint), 24'h000001);
    chk1(nbusy >= 190 && nbusy <= 210, 1'b1);
    exp_pos = next_pos(exp_pos, 8'h44, 24'd50, 1'b0);
    chk24(current_position_counter, exp_pos);
    host.write_reg(8'h87, 24'h000102);
    run(8'h4C, 8'hE0, 24'd5, 8'h11);
    chk24(current_position_counter, exp_pos);
    chk1(dir_out_q, 1'b1);
    chk24(24'(npul), 24'd5);
    host.write_reg(8'h87, 24'h000002);
    // Stop pin, immediate stop, then decelerating stop, each with a long count pending
    for (int j = 0; j < 3; j++) begin
      start_run(8'h44, 8'hE2, 24'd1000, 8'h11);
      repeat (40) @(negedge core_clk);
      if (j == 0) stop_n = 1'b0;
      else if (j == 1) host.send_cmd(8'h08);
      else host.send_cmd(8'h1D);
      repeat (8) @(negedge core_clk);
      chk1(busy_q, 1'b0);
      chk1(feed_amount_counter !== 24'h000000, 1'b1);
      stop_n = 1'b1;
    end
    sf = feed_amount_counter;
    sp = current_position_counter;
    nint = 0;
    host.send_cmd(8'h08);
    host.send_cmd(8'h1D);
    repeat (4) @(negedge core_clk);
    chk24(24'(nint), 24'h000000);
    chk24(feed_amount_counter, sf);
    chk24(current_position_counter, sp);
    run(8'h45, 8'hE0, 24'd7, 8'h11);
    chk24(24'(npul), 24'd7);
    start_run(8'h45, 8'hE0, 24'd500, 8'h11);
    repeat (60) @(negedge core_clk);
    origin_n = 1'b0;
    repeat (8) @(negedge core_clk);
    chk1(busy_q, 1'b0);
    run(8'h41, 8'hE0, 24'd5, 8'h30);
    chk24(24'(nbusy), 24'h000000);
    chk24(24'(nint), 24'h000001);
    origin_n = 1'b1;
    // Start speed half the run speed: a pulse every 4 cycles, every 8 once slowed
    host.write_reg(8'h81, 24'h000800);
    start_run(8'h43, 8'hE0, 24'd5, 8'h11);
    repeat (40) @(negedge core_clk);
    npul = 0;
    repeat (80) @(negedge core_clk);
    chk1(npul >= 19 && npul <= 21, 1'b1);
    slow_n = 1'b0;
    repeat (8) @(negedge core_clk);
    npul = 0;
    repeat (80) @(negedge core_clk);
    chk1(npul >= 9 && npul <= 11, 1'b1);
    chk1(busy_q, 1'b1);
    origin_n = 1'b0;
    repeat (8) @(negedge core_clk);
    chk1(busy_q, 1'b0);
    tally_and_finish();
  end
endmodule // stepper_pulse_mode_sequencer_tb_top
